// File: core/nvc_params.svh
// Offsets, field positions, reset values and timing counts of the EEPROM byte access controller.
`ifndef NVC_PARAMS_SVH
`define NVC_PARAMS_SVH

`define NVC_OFS_IRQ_MASK   6'h1a
`define NVC_OFS_IRQ_STAT   6'h1b
`define NVC_OFS_CTRL       6'h1c
`define NVC_OFS_DATA       6'h1d
`define NVC_OFS_ADDR       6'h1e

`define NVC_BIT_READ       0
`define NVC_BIT_STROBE     1
`define NVC_BIT_ARM        2
`define NVC_MODE_LSB       4
`define NVC_MODE_MSB       5

`define NVC_MODE_ATOMIC    2'h0
`define NVC_MODE_ERASE     2'h1
`define NVC_MODE_WRITE     2'h2
`define NVC_MODE_RSVD      2'h3

`define NVC_IRQ_DONE       0
`define NVC_IRQ_REFUSED    1

`define NVC_RST_ADDR       8'h00
`define NVC_RST_DATA       8'h00
`define NVC_RST_MODE       2'h0
`define NVC_RST_IRQ        2'h0
`define NVC_ERASED_BYTE    8'hff

`define NVC_READ_STALL     3'h4
`define NVC_PROG_STALL     3'h2
`define NVC_ARM_WINDOW     3'h4

`define NVC_ERASE_TIME_US  2000
`define NVC_WRITE_TIME_US  2000
`define NVC_OSC_KHZ        8000
`define NVC_ERASE_TICKS    (`NVC_ERASE_TIME_US * `NVC_OSC_KHZ / 1000)
`define NVC_WRITE_TICKS    (`NVC_WRITE_TIME_US * `NVC_OSC_KHZ / 1000)

`define NVC_MEM_BYTES      256

`endif

// File: core/nvc_pkg.sv
// Types shared by the EEPROM byte access controller files.
package nvc_pkg;

   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } nvc_bus_req_s;

   typedef struct packed {
      logic [1:0] mode;
      logic [7:0] addr;
      logic [7:0] data;
   } nvc_op_s;

   typedef enum logic [1:0] {
      NVC_IDLE,
      NVC_ERASE,
      NVC_WRITE
   } nvc_state_e;

endpackage

// File: core/nvc_prog_engine.sv
// Programming engine with the byte array, timed by the calibrated oscillator tick.
`timescale 1ns/10ps
`include "nvc_params.svh"
module nvc_prog_engine #(
   parameter int unsigned          CNT_W       = 16,
   parameter logic [CNT_W-1:0]     ERASE_TICKS = CNT_W'(`NVC_ERASE_TICKS),
   parameter logic [CNT_W-1:0]     WRITE_TICKS = CNT_W'(`NVC_WRITE_TICKS),
   parameter int unsigned          MEM_BYTES   = `NVC_MEM_BYTES
) (
   input  wire logic               clk_sys,
   input  wire logic               npor,
   input  wire logic               tick,
   input  wire logic               start,
   input  wire nvc_pkg::nvc_op_s   op,
   input  wire logic [7:0]         rd_addr,
   output logic [7:0]              rd_data,
   output logic                    busy,
   output logic                    done
);
   import nvc_pkg::*;

   nvc_state_e           state;
   nvc_state_e           next_state;
   nvc_op_s              cur;
   logic [CNT_W-1:0]     cnt;
   logic [CNT_W-1:0]     next_cnt;
   logic [7:0]           mem [MEM_BYTES];

   // Only oscillator ticks advance the phase counter, so CPU clock changes do not alter program time. [R12]
   wire phase_end = tick && (cnt == CNT_W'(1));
   wire erase_fin = (state == NVC_ERASE) && phase_end;
   wire write_fin = (state == NVC_WRITE) && phase_end;
   wire op_fin    = write_fin || (erase_fin && cur.mode == `NVC_MODE_ERASE);

   assign rd_data = mem[rd_addr]; // [R13] [R16]

   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         NVC_IDLE: begin
            if (start && op.mode == `NVC_MODE_WRITE) begin // [R5]
               next_state = NVC_WRITE;
               next_cnt   = WRITE_TICKS;
            end else if (start) begin // [R3] [R4]
               next_state = NVC_ERASE;
               next_cnt   = ERASE_TICKS;
            end
         end
         NVC_ERASE: begin
            if (phase_end && cur.mode == `NVC_MODE_ATOMIC) begin // [R3]
               next_state = NVC_WRITE;
               next_cnt   = WRITE_TICKS;
            end else if (phase_end) begin
               next_state = NVC_IDLE;
            end else if (tick) begin // [R12]
               next_cnt = cnt - CNT_W'(1);
            end
         end
         NVC_WRITE: begin
            if (phase_end) begin
               next_state = NVC_IDLE;
            end else if (tick) begin // [R12]
               next_cnt = cnt - CNT_W'(1);
            end
         end
         default: next_state = NVC_IDLE;
      endcase
   end

   // Powered by its own reset so that a CPU reset cannot cut a byte short. [R17]
   always_ff @(posedge clk_sys or negedge npor) begin
      if (!npor) begin
         state <= NVC_IDLE;
         cnt   <= '0;
         cur   <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         busy  <= (next_state != NVC_IDLE); // [R6] [R7] [R8]
         done  <= op_fin;
         if (state == NVC_IDLE && start) begin
            cur <= op;
         end
      end
   end

   // A write only clears bits, so an unerased byte ends up as the AND of old and new. [R11]
   always_ff @(posedge clk_sys) begin
      if (erase_fin) begin
         mem[cur.addr] <= `NVC_ERASED_BYTE; // [R4]
      end else if (write_fin) begin
         mem[cur.addr] <= mem[cur.addr] & cur.data; // [R5]
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!npor);

   atomic_order_a: assert property (state == NVC_IDLE && start && op.mode == `NVC_MODE_ATOMIC
                                    |=> state == NVC_ERASE) // [R3]
      else $error("atomic programming did not begin with the erase phase");
   atomic_result_a: assert property (done && cur.mode == `NVC_MODE_ATOMIC |-> mem[cur.addr] == cur.data) // [R3]
      else $error("atomic programming left a wrong byte");
   erase_result_a: assert property (done && cur.mode == `NVC_MODE_ERASE |-> mem[cur.addr] == `NVC_ERASED_BYTE) // [R4]
      else $error("erase left a byte that is not erased");
   write_result_a: assert property (done && cur.mode == `NVC_MODE_WRITE
                                    |-> (mem[cur.addr] & ~cur.data) == 8'h00) // [R5]
      else $error("write left a bit set that the data clears");
   busy_end_a: assert property ($fell(busy) |-> done) // [R6]
      else $error("busy fell without a completed operation");
   tick_only_a: assert property (state != NVC_IDLE && !tick |=> $stable(cnt)) // [R12]
      else $error("program timer moved without an oscillator tick");
   no_restart_a: assert property (state != NVC_IDLE |=> $stable(cur)) // [R8]
      else $error("operation parameters changed while programming");

endmodule // nvc_prog_engine

// File: core/nvc_eeprom_ctrl.sv
// EEPROM byte access controller top: register port, arming window, CPU stalls and interrupt.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "nvc_params.svh"
// Notes on behaviour
// [R1] - A started read holds the CPU stall output for four clock cycles.
// [R2] - A started programming operation holds the CPU stall output for two cycles.
// [R3] - Mode zero plus strobe inside the arm window erases then writes the byte.
// [R4] - Mode one plus armed strobe erases the addressed byte only.
// [R5] - Mode two plus armed strobe writes the data register into the byte.
// [R6] - Strobe bit reads set through an atomic operation, clears when it finishes.
// [R7] - Strobe bit reads set through an erase-only operation, clears at its end.
// [R8] - While programming, further reads, erases and writes are refused.
// [R9] - Software loads address and data before an atomic or write-only start.
// [R10] - Software loads the address before an erase-only start.
// [R11] - Software erases a byte before writing it in split mode.
// [R12] - Erase and write durations count calibrated oscillator ticks, not CPU cycles.
// [R13] - The data space is 256 linear bytes, accessed one byte at a time.
// [R14] - Address, data and control registers sit in the I/O register space.
// [R15] - Software keeps interrupts off between arming and strobing.
// [R16] - Setting the read strobe copies the addressed byte into the data register.
// [R17] - A programming operation in progress survives a CPU reset and completes.
// [R18] - The arm bit clears four cycles after being set; later strobes do nothing.
// [R19] - Software waits for the strobe bit to clear before changing setup.
module nvc_eeprom_ctrl #(
   parameter int unsigned          CNT_W       = 16,
   parameter logic [CNT_W-1:0]     ERASE_TICKS = CNT_W'(`NVC_ERASE_TICKS),
   parameter logic [CNT_W-1:0]     WRITE_TICKS = CNT_W'(`NVC_WRITE_TICKS),
   parameter int unsigned          MEM_BYTES   = `NVC_MEM_BYTES
) (
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   input  wire logic                  npor,
   input  wire logic                  cal_osc,
   input  wire nvc_pkg::nvc_bus_req_s bus_req,
   output logic [7:0]                 bus_rdata,
   output logic                       cpu_stall,
   output logic                       irq
);
   import nvc_pkg::*;

   function automatic logic [2:0] nvc_max3(input logic [2:0] a, input logic [2:0] b);
      nvc_max3 = (a > b) ? a : b;
   endfunction

   function automatic logic [2:0] nvc_dec3(input logic [2:0] a);
      nvc_dec3 = (a != 3'h0) ? a - 3'h1 : 3'h0;
   endfunction

   logic              osc_meta;
   logic              osc_sync;
   logic              osc_prev;
   logic [7:0]        nv_address_low;
   logic [7:0]        nv_data_register;
   logic [1:0]        program_mode_field;
   logic              program_arm;
   logic [2:0]        arm_cnt;
   logic [2:0]        stall_cnt;
   logic [1:0]        irq_status;
   logic [1:0]        irq_mask;
   logic              busy;
   logic              eng_done;
   logic [7:0]        eng_rd_data;
   nvc_op_s           eng_op;

   // The oscillator edge is only looked at after two flops, so its phase to clk_sys does not matter.
   wire osc_tick = osc_sync && !osc_prev; // [R12]

   // Address decode of the I/O register window. [R14]
   wire sel_ctrl  = (bus_req.addr == `NVC_OFS_CTRL);
   wire sel_data  = (bus_req.addr == `NVC_OFS_DATA);
   wire sel_addr  = (bus_req.addr == `NVC_OFS_ADDR);
   wire sel_stat  = (bus_req.addr == `NVC_OFS_IRQ_STAT);
   wire sel_mask  = (bus_req.addr == `NVC_OFS_IRQ_MASK);
   wire wr_ctrl   = bus_req.wr && sel_ctrl;
   wire wr_data   = bus_req.wr && sel_data;
   wire wr_addr   = bus_req.wr && sel_addr;
   wire wr_stat   = bus_req.wr && sel_stat;
   wire wr_mask   = bus_req.wr && sel_mask;

   wire       want_read  = wr_ctrl && bus_req.wdata[`NVC_BIT_READ];
   wire       want_prog  = wr_ctrl && bus_req.wdata[`NVC_BIT_STROBE] && program_arm; // [R18]
   wire       mode_legal = (program_mode_field != `NVC_MODE_RSVD);
   wire       prog_start = want_prog && !busy && mode_legal; // [R3] [R4] [R5] [R8]
   wire       rd_start   = want_read && !busy && !prog_start; // [R8] [R16]
   wire       refused    = (want_read || want_prog) && busy; // [R8]
   wire       set_arm    = wr_ctrl && bus_req.wdata[`NVC_BIT_ARM] && !busy;
   wire [1:0] new_mode   = bus_req.wdata[`NVC_MODE_MSB:`NVC_MODE_LSB];

   // A reload never shortens a stall that is already running.
   wire [2:0] stall_dec      = nvc_dec3(stall_cnt);
   wire [2:0] next_stall_cnt = rd_start   ? nvc_max3(stall_dec, `NVC_READ_STALL) : // [R1]
                               prog_start ? nvc_max3(stall_dec, `NVC_PROG_STALL) : // [R2]
                               stall_dec;

   // The window closes early once a strobe has used it, so one arming gives one start.
   wire [2:0] next_arm_cnt = set_arm    ? `NVC_ARM_WINDOW :
                             prog_start ? 3'h0 :
                             nvc_dec3(arm_cnt); // [R18]

   wire [1:0] events          = {refused, eng_done};
   wire [1:0] stat_clear      = wr_stat ? bus_req.wdata[1:0] : 2'h0;
   // Set wins over a write-one-to-clear landing in the same cycle.
   wire [1:0] next_irq_status = (irq_status & ~stat_clear) | events;

   wire [7:0] ctrl_view = {2'h0, program_mode_field, 1'b0, program_arm, busy, 1'b0}; // [R6] [R7]
   wire [7:0] rd_mux    = sel_ctrl ? ctrl_view :
                          sel_data ? nv_data_register :
                          sel_addr ? nv_address_low :
                          sel_stat ? {6'h00, irq_status} :
                          sel_mask ? {6'h00, irq_mask} :
                          8'h00;
   wire [7:0] next_rdata = bus_req.rd ? rd_mux : 8'h00;

   assign eng_op = '{mode: program_mode_field, addr: nv_address_low, data: nv_data_register}; // [R9] [R10]

   always_ff @(posedge clk_sys or negedge npor) begin
      if (!npor) begin
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
         osc_prev <= 1'b0;
      end else begin
         osc_meta <= cal_osc;
         osc_sync <= osc_meta;
         osc_prev <= osc_sync;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         nv_address_low <= `NVC_RST_ADDR;
      end else if (wr_addr) begin
         nv_address_low <= bus_req.wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         nv_data_register <= `NVC_RST_DATA;
      end else if (rd_start) begin
         nv_data_register <= eng_rd_data; // [R16]
      end else if (wr_data) begin
         nv_data_register <= bus_req.wdata;
      end
   end

   // Mode writes during programming are dropped instead of corrupting the running operation.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         program_mode_field <= `NVC_RST_MODE;
      end else if (wr_ctrl && !busy) begin
         program_mode_field <= new_mode; // [R19]
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         arm_cnt     <= 3'h0;
         program_arm <= 1'b0;
      end else begin
         arm_cnt     <= next_arm_cnt;
         program_arm <= (next_arm_cnt != 3'h0); // [R18]
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         stall_cnt <= 3'h0;
         cpu_stall <= 1'b0;
      end else begin
         stall_cnt <= next_stall_cnt;
         cpu_stall <= (next_stall_cnt != 3'h0); // [R1] [R2]
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         irq_status <= `NVC_RST_IRQ;
         irq_mask   <= `NVC_RST_IRQ;
         irq        <= 1'b0;
         bus_rdata  <= 8'h00;
      end else begin
         irq_status <= next_irq_status;
         if (wr_mask) begin
            irq_mask <= bus_req.wdata[1:0];
         end
         irq        <= |(next_irq_status & (wr_mask ? bus_req.wdata[1:0] : irq_mask));
         bus_rdata  <= next_rdata;
      end
   end

   nvc_prog_engine #(
      .CNT_W       (CNT_W),
      .ERASE_TICKS (ERASE_TICKS),
      .WRITE_TICKS (WRITE_TICKS),
      .MEM_BYTES   (MEM_BYTES)
   ) u_engine (
      .clk_sys (clk_sys),
      .npor    (npor),
      .tick    (osc_tick),
      .start   (prog_start),
      .op      (eng_op),
      .rd_addr (nv_address_low),
      .rd_data (eng_rd_data),
      .busy    (busy),
      .done    (eng_done)
   ); // [R17]

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   read_stall_a: assert property (rd_start |=> cpu_stall [*4]) // [R1]
      else $error("read stall shorter than four cycles");
   read_stall_end_a: assert property (rd_start && stall_cnt == 3'h0 ##1 (!rd_start && !prog_start) [*4]
                                      |=> !cpu_stall) // [R1]
      else $error("read stall longer than four cycles");
   prog_stall_a: assert property (prog_start && stall_cnt == 3'h0 |=> cpu_stall ##1 cpu_stall
                                  ##1 (!cpu_stall || $past(rd_start) || $past(prog_start))) // [R2]
      else $error("program stall is not two cycles");
   prog_busy_a: assert property (prog_start |=> busy && ctrl_view[`NVC_BIT_STROBE]) // [R6] [R7]
      else $error("strobe bit not set after a programming start");
   arm_open_a: assert property (set_arm |=> program_arm && arm_cnt == `NVC_ARM_WINDOW) // [R18]
      else $error("arm window did not open");
   arm_close_a: assert property (set_arm ##1 (!set_arm) [*4] |=> !program_arm) // [R18]
      else $error("arm bit outlived its four-cycle window");
   unarmed_a: assert property (wr_ctrl && bus_req.wdata[`NVC_BIT_STROBE] && !program_arm && !busy
                               |=> !busy) // [R18]
      else $error("unarmed strobe started an operation");
   refuse_read_a: assert property (want_read && busy |=> $stable(nv_data_register)) // [R8]
      else $error("read performed while programming");
   refuse_mode_a: assert property (wr_ctrl && busy |=> $stable(program_mode_field)) // [R8]
      else $error("mode changed while programming");
   read_data_a: assert property (rd_start |=> nv_data_register == $past(eng_rd_data)) // [R16]
      else $error("read did not load the addressed byte");
   irq_level_a: assert property (irq == |(irq_status & irq_mask))
      else $error("interrupt output does not follow status and mask");
   set_wins_a: assert property (eng_done |=> irq_status[`NVC_IRQ_DONE])
      else $error("completion event lost");

   read_seen_c: cover property (rd_start ##1 cpu_stall);
   atomic_seen_c: cover property (prog_start && program_mode_field == `NVC_MODE_ATOMIC);
   erase_seen_c: cover property (prog_start && program_mode_field == `NVC_MODE_ERASE);
   done_seen_c: cover property (eng_done ##1 irq);
   refuse_seen_c: cover property (refused);

endmodule // nvc_eeprom_ctrl

// File: verif/nvc_osc_model.sv
// Behavioural model of the calibrated oscillator that times programming.
`timescale 1ns/10ps
module nvc_osc_model #(
   parameter realtime HALF_NS = 130.0
) (
   input  wire logic run,
   output logic      cal_osc
);
   // The half period is not a multiple of the CPU clock, so ticks drift against it.
   initial cal_osc = 1'b0;
   always begin
      #(HALF_NS);
      if (run) begin
         cal_osc = ~cal_osc;
      end
   end
endmodule // nvc_osc_model

// File: verif/tb.sv
// Self-checking testbench of the EEPROM byte access controller.
`timescale 1ns/10ps
`include "nvc_params.svh"
module tb;
   import nvc_pkg::*;
   logic                clk_sys;
   logic                nrst;
   logic                npor;
   logic                run;
   logic                cal_osc;
   nvc_bus_req_s        req;
   logic [7:0]          bus_rdata;
   logic                cpu_stall;
   logic                irq;
   int                  fail_count;
   int                  checks;

   nvc_osc_model osc (.run(run), .cal_osc(cal_osc));

   nvc_eeprom_ctrl #(.ERASE_TICKS(16'h3), .WRITE_TICKS(16'h4)) dut (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .npor      (npor),
      .cal_osc   (cal_osc),
      .bus_req   (req),
      .bus_rdata (bus_rdata),
      .cpu_stall (cpu_stall),
      .irq       (irq)
   );

   initial clk_sys = 1'b0;
   always #20 clk_sys = ~clk_sys;

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      req.addr  <= a;
      req.wdata <= d;
      req.wr    <= 1'b1;
      @(posedge clk_sys);
      req.wr    <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      req.addr <= a;
      req.rd   <= 1'b1;
      @(posedge clk_sys);
      req.rd   <= 1'b0;
      #1 d = bus_rdata;
   endtask

   task automatic rd_chk(input string name, input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(name, exp, d);
   endtask

   // Counts the cycles of stall that follow the write just taken.
   task automatic stall_len(input logic [7:0] exp);
      logic [7:0] n;
      n = 8'h00;
      #1;
      while (cpu_stall === 1'b1 && n < 8'h14) begin
         n++;
         @(posedge clk_sys);
         #1;
      end
      chk("stall cycles", exp, n);
   endtask

   // Polling keeps setup untouched while an operation runs.
   task automatic wait_idle();
      logic [7:0] d;
      int         n;
      n = 0;
      d = 8'h02;
      while (d[1] !== 1'b0 && n < 300) begin
         rd(`NVC_OFS_CTRL, d);
         n++;
      end
      if (n >= 300) begin
         fail_count++;
         $display("unexpected busy: expected 00, seen %h", d);
         give_verdict();
      end
   endtask

   // Interrupts are assumed off between arm and strobe, so the writes are adjacent.
   task automatic prog(input logic [1:0] mode, input logic [7:0] a, input logic [7:0] d);
      wr(`NVC_OFS_ADDR, a);
      wr(`NVC_OFS_DATA, d);
      wr(`NVC_OFS_CTRL, {2'b00, mode, 4'h4});
      wr(`NVC_OFS_CTRL, {2'b00, mode, 4'h2});
      stall_len(8'h02);
   endtask

   task automatic read_byte(input logic [7:0] a, input logic [7:0] exp);
      wr(`NVC_OFS_ADDR, a);
      wr(`NVC_OFS_CTRL, 8'h01);
      stall_len(8'h04);
      rd_chk("byte", `NVC_OFS_DATA, exp);
   endtask

   initial begin
      #400000;
      fail_count++;
      $display("unexpected run length: expected 00, seen 01");
      give_verdict();
   end

   initial begin
      fail_count = 0;
      checks     = 0;
      nrst       = 1'b0;
      npor       = 1'b0;
      run        = 1'b1;
      req        = '0;
      repeat (6) @(posedge clk_sys);
      nrst <= 1'b1;
      npor <= 1'b1;
      rd_chk("address", `NVC_OFS_ADDR, `NVC_RST_ADDR);
      rd_chk("data", `NVC_OFS_DATA, `NVC_RST_DATA);
      rd_chk("control", `NVC_OFS_CTRL, 8'h00);
      rd_chk("unmapped", 6'h00, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      // Atomic erase and write at the top byte.
      prog(`NVC_MODE_ATOMIC, 8'hff, 8'h5a);
      rd_chk("control busy", `NVC_OFS_CTRL, 8'h02);
      wait_idle();
      read_byte(8'hff, 8'h5a);
      // Strobe after the arm window has lapsed.
      wr(`NVC_OFS_ADDR, 8'h10);
      wr(`NVC_OFS_CTRL, 8'h04);
      rd_chk("live arm", `NVC_OFS_CTRL, 8'h04);
      @(posedge clk_sys);
      wr(`NVC_OFS_CTRL, 8'h02);
      rd_chk("late strobe", `NVC_OFS_CTRL, 8'h00);
      // Reserved mode: an armed strobe starts nothing and the arm stays live.
      wr(`NVC_OFS_CTRL, 8'h34);
      wr(`NVC_OFS_CTRL, 8'h32);
      rd_chk("reserved mode", `NVC_OFS_CTRL, 8'h34);
      // Erase only, with the oscillator halted to show who times it.
      wr(`NVC_OFS_IRQ_STAT, 8'h03);
      run <= 1'b0;
      prog(`NVC_MODE_ERASE, 8'hff, 8'h00);
      rd_chk("erase busy", `NVC_OFS_CTRL, 8'h12);
      wr(`NVC_OFS_CTRL, 8'h11);
      repeat (60) @(posedge clk_sys);
      rd_chk("held busy", `NVC_OFS_CTRL, 8'h12);
      rd_chk("refused flag", `NVC_OFS_IRQ_STAT, 8'h02);
      chk("masked irq", 8'h00, {7'h00, irq});
      run <= 1'b1;
      wait_idle();
      rd_chk("status", `NVC_OFS_IRQ_STAT, 8'h03);
      wr(`NVC_OFS_IRQ_MASK, 8'h01);
      rd_chk("mask", `NVC_OFS_IRQ_MASK, 8'h01);
      chk("irq raised", 8'h01, {7'h00, irq});
      wr(`NVC_OFS_IRQ_STAT, 8'h01);
      rd_chk("cleared", `NVC_OFS_IRQ_STAT, 8'h02);
      chk("irq cleared", 8'h00, {7'h00, irq});
      read_byte(8'hff, `NVC_ERASED_BYTE);
      // Write only onto the erased byte.
      prog(`NVC_MODE_WRITE, 8'hff, 8'h3c);
      wait_idle();
      read_byte(8'hff, 8'h3c);
      // A CPU reset in mid-operation must not cut it short.
      prog(`NVC_MODE_ATOMIC, 8'h22, 8'ha5);
      @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      rd_chk("busy after reset", `NVC_OFS_CTRL, 8'h02);
      wait_idle();
      read_byte(8'h22, 8'ha5);
      give_verdict();
   end
endmodule // tb
